//--- rtl/pfswc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PFSWC_DEFS_SVH
`define PFSWC_DEFS_SVH
`define PFSWC_OFS_DATA_LOW 3'h0
`define PFSWC_OFS_DATA_HIGH 3'h1
`define PFSWC_OFS_ADDR_LOW 3'h2
`define PFSWC_OFS_ADDR_HIGH 3'h3
`define PFSWC_OFS_CONTROL 3'h4
`define PFSWC_OFS_UNLOCK 3'h5
`define PFSWC_BIT_CALIB_SPACE_SELECT 6
`define PFSWC_BIT_PROG_WRITE_ENABLE 2
`define PFSWC_BIT_WRITE 1
`define PFSWC_BIT_READ 0
`define PFSWC_CTRL_RESET 8'h00
`define PFSWC_UNLOCK_FIRST 8'h55
`define PFSWC_UNLOCK_SECOND 8'hAA
`define PFSWC_CLK_HZ 40000000
`define PFSWC_ERASE_MS 4
`define PFSWC_PWRUP_MS 72
`define PFSWC_ERASE_CYCLES ((`PFSWC_ERASE_MS * `PFSWC_CLK_HZ) / 1000)
`define PFSWC_PWRUP_CYCLES ((`PFSWC_PWRUP_MS * `PFSWC_CLK_HZ) / 1000)
`define PFSWC_SETUP_CYCLES 2
`endif

//--- rtl/pfswc_pkg.sv
// types shared by the flash self-write controller
package pfswc_pkg;
  typedef enum logic [2:0] {
    PFSWC_IDLE,
    PFSWC_READ,
    PFSWC_SETUP,
    PFSWC_ERASE,
    PFSWC_PROG
  } pfswc_state_e;
  typedef enum logic [1:0] {
    PFSWC_UNL_NONE,
    PFSWC_UNL_FIRST,
    PFSWC_UNL_ARMED
  } pfswc_unlock_e;
endpackage : pfswc_pkg

//--- rtl/pfswc_unlock.sv
// unlock sequence tracker for flash writes
`timescale 1ns/100ps
`include "pfswc_defs.svh"
module pfswc_unlock (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic armed
);
  pfswc_pkg::pfswc_unlock_e state_reg;

  // any register write other than the exact next step drops the sequence
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= pfswc_pkg::PFSWC_UNL_NONE;
    end else if (reg_wr) begin
      if (reg_addr == `PFSWC_OFS_UNLOCK &&
          reg_wdata == `PFSWC_UNLOCK_FIRST) begin
        state_reg <= pfswc_pkg::PFSWC_UNL_FIRST;
      end else if (reg_addr == `PFSWC_OFS_UNLOCK &&
                   reg_wdata == `PFSWC_UNLOCK_SECOND &&
                   state_reg == pfswc_pkg::PFSWC_UNL_FIRST) begin
        state_reg <= pfswc_pkg::PFSWC_UNL_ARMED;
      end else begin
        state_reg <= pfswc_pkg::PFSWC_UNL_NONE;
      end
    end
  end

  assign armed = (state_reg == pfswc_pkg::PFSWC_UNL_ARMED);
endmodule : pfswc_unlock

//--- rtl/pfswc_ctrl.sv
// flash self-read/self-write controller behind the processor registers
// Notes on behaviour
// - calibration select set makes reads come from the calibration area.
// - write enable bit clear inhibits every write cycle.
// - write start set begins a write; only hardware clears it.
// - read start runs a one-cycle read; only hardware clears it.
// - control bits 7 and 5..3 always read as zero.
// - read takes the first cycle after start; that cycle is discarded.
// - read data lands next cycle and holds until next read or write.
// - writes go in aligned four-word blocks, never crossing a boundary.
// - each word needs address, data, then 55h, AAh, then write start.
// - software writes block words in order 00, 01, 10, 11.
// - first three words only fill the buffer, halting just the two setup cycles.
// - last word programs four buffered words; the 16-word row is erased first only at nibble 0011.
// - erase only when write start hits address low nibble 0011.
// - two setup cycles follow write start; for block words 00, 01, 10 the processor then resumes.
// - processor halts about 4 ms during erase/program; clocks keep running.
// - write enable clear at power-up; writes blocked until timer expires.
// - write-protected regions refuse writes, except in serial programming.
// - code protection keeps processor access but disables test access.
// - a write attempted with calibration select set changes nothing.
// - the unlock register stores nothing and reads as zero.
// - data word is 14 bits, address is 13 bits.
`timescale 1ns/100ps
`include "pfswc_defs.svh"
module pfswc_ctrl #(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 14,
  parameter int BLOCK_WORDS = 4,
  parameter int ROW_WORDS = 16,
  parameter int SETUP_CYCLES = `PFSWC_SETUP_CYCLES,
  parameter int ERASE_CYCLES = `PFSWC_ERASE_CYCLES,
  parameter int PWRUP_CYCLES = `PFSWC_PWRUP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] write_protect_bits,
  input wire logic code_protect_bit,
  input wire logic serial_programming_mode,
  input wire logic test_access_req,
  output logic test_access_en,
  output logic cpu_halt,
  output logic fetch_steal,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_calib_sel,
  output logic flash_read,
  input wire logic [DATA_W-1:0] flash_rdata,
  output logic flash_erase_row,
  output logic flash_prog_block,
  output logic [BLOCK_WORDS*DATA_W-1:0] flash_prog_data
);
  initial begin
    if (ADDR_W != 13 || DATA_W != 14 || BLOCK_WORDS != 4 ||
        ROW_WORDS != 16 || SETUP_CYCLES < 1 || ERASE_CYCLES < 1 ||
        PWRUP_CYCLES < 1) begin
      $error("pfswc_ctrl: unsupported parameter values");
    end
  end

  localparam int BW = $clog2(BLOCK_WORDS);
  localparam int CW = 32;

  pfswc_pkg::pfswc_state_e state_reg;
  logic [7:0] data_low_reg;
  logic [5:0] data_high_reg;
  logic [7:0] addr_low_reg;
  logic [4:0] addr_high_reg;
  logic calib_space_select_reg;
  logic prog_write_enable_reg;
  logic wr_bit_reg;
  logic rd_bit_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] pwrup_cnt_reg;
  logic pwrup_done_reg;
  logic [DATA_W-1:0] buf_reg [BLOCK_WORDS];
  logic [ADDR_W-1:0] full_addr;
  logic armed;
  logic ctrl_wr;
  logic write_go;
  logic last_word;
  logic [1:0] rd_sync_reg;
  logic [1:0] wp_sync0_reg;
  logic [1:0] wp_sync1_reg;
  logic [2:0] cp_sync_reg;
  logic [2:0] sp_sync_reg;

  assign full_addr = {addr_high_reg, addr_low_reg};
  assign ctrl_wr = reg_wr && reg_addr == `PFSWC_OFS_CONTROL;
  assign last_word = (addr_low_reg[BW-1:0] == BW'(BLOCK_WORDS - 1));

  // strap pins come from outside and pass flip-flops first: two for write protect, three for code protect and serial mode
  always_ff @(posedge ref_clk) begin
    wp_sync0_reg <= write_protect_bits;
    wp_sync1_reg <= wp_sync0_reg;
    cp_sync_reg <= {cp_sync_reg[1:0], code_protect_bit};
    sp_sync_reg <= {sp_sync_reg[1:0], serial_programming_mode};
    rd_sync_reg <= {rd_sync_reg[0], test_access_req};
  end

  // protected region decode: 00 none, 01 low half, 10 low quarter, 11 none
  function automatic logic pfswc_protected(input logic [1:0] wp,
                                           input logic [ADDR_W-1:0] a);
    case (wp)
      2'b01: pfswc_protected = (a[ADDR_W-1] == 1'b0);
      2'b10: pfswc_protected = (a[ADDR_W-1:ADDR_W-2] == 2'b00);
      default: pfswc_protected = 1'b0;
    endcase
  endfunction : pfswc_protected

  pfswc_unlock u_unlock (
    .ref_clk(ref_clk),
    .srst(srst),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .armed(armed)
  );

  // a write starts only with enable, unlock, timer done, no calib_space_select, no lock
  assign write_go = ctrl_wr && reg_wdata[`PFSWC_BIT_WRITE] && !wr_bit_reg &&
                    state_reg == pfswc_pkg::PFSWC_IDLE &&
                    prog_write_enable_reg &&
                    armed &&
                    pwrup_done_reg &&
                    !calib_space_select_reg &&
                    !(pfswc_protected({wp_sync1_reg[1], wp_sync1_reg[0]},
                                      full_addr) &&
                      !sp_sync_reg[2]);

  // power-up timer blocks writes until it runs out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwrup_cnt_reg <= '0;
      pwrup_done_reg <= 1'b0;
    end else if (!pwrup_done_reg) begin
      pwrup_cnt_reg <= pwrup_cnt_reg + 1'b1;
      pwrup_done_reg <= (pwrup_cnt_reg == CW'(PWRUP_CYCLES - 1));
    end
  end

  // control bits: enable and calib_space_select plain, start bits set-only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      calib_space_select_reg <= 1'(`PFSWC_CTRL_RESET >> `PFSWC_BIT_CALIB_SPACE_SELECT);
      prog_write_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      calib_space_select_reg <= reg_wdata[`PFSWC_BIT_CALIB_SPACE_SELECT];
      prog_write_enable_reg <= reg_wdata[`PFSWC_BIT_PROG_WRITE_ENABLE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_bit_reg <= 1'b0;
    end else if (ctrl_wr && reg_wdata[`PFSWC_BIT_READ] && !write_go &&
                 state_reg == pfswc_pkg::PFSWC_IDLE) begin
      rd_bit_reg <= 1'b1;
    end else if (state_reg == pfswc_pkg::PFSWC_READ) begin
      rd_bit_reg <= 1'b0;
    end
  end

  // writing zero never clears the bit, so a write cannot be cut short
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_bit_reg <= 1'b0;
    end else if (write_go) begin
      wr_bit_reg <= 1'b1;
    end else if (state_reg == pfswc_pkg::PFSWC_SETUP && cnt_reg == '0 &&
                 !last_word) begin
      wr_bit_reg <= 1'b0;
    end else if (state_reg == pfswc_pkg::PFSWC_PROG) begin
      wr_bit_reg <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= pfswc_pkg::PFSWC_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        pfswc_pkg::PFSWC_IDLE: begin
          if (write_go) begin
            state_reg <= pfswc_pkg::PFSWC_SETUP;
            cnt_reg <= CW'(SETUP_CYCLES - 1);
          end else if (ctrl_wr && reg_wdata[`PFSWC_BIT_READ]) begin
            state_reg <= pfswc_pkg::PFSWC_READ;
          end
        end
        pfswc_pkg::PFSWC_READ: begin
          state_reg <= pfswc_pkg::PFSWC_IDLE;
        end
        pfswc_pkg::PFSWC_SETUP: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (last_word) begin
            state_reg <= pfswc_pkg::PFSWC_ERASE;
            cnt_reg <= CW'(ERASE_CYCLES - 1);
          end else begin
            state_reg <= pfswc_pkg::PFSWC_IDLE;
          end
        end
        pfswc_pkg::PFSWC_ERASE: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            state_reg <= pfswc_pkg::PFSWC_PROG;
          end
        end
        pfswc_pkg::PFSWC_PROG: begin
          state_reg <= pfswc_pkg::PFSWC_IDLE;
        end
        default: begin
          state_reg <= pfswc_pkg::PFSWC_IDLE;
        end
      endcase
    end
  end

  // buffer word chosen by the low address bits, so a block never spans two
  genvar gi;
  generate
    for (gi = 0; gi < BLOCK_WORDS; gi++) begin : g_buf
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          buf_reg[gi] <= '0;
        end else if (write_go && addr_low_reg[BW-1:0] == BW'(gi)) begin
          buf_reg[gi] <= {data_high_reg, data_low_reg};
        end
      end
      assign flash_prog_data[gi*DATA_W +: DATA_W] = buf_reg[gi];
    end
  endgenerate

  // address and data registers; a read result overwrites the data pair
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_low_reg <= '0;
      addr_high_reg <= '0;
    end else if (reg_wr && state_reg == pfswc_pkg::PFSWC_IDLE) begin
      if (reg_addr == `PFSWC_OFS_ADDR_LOW) begin
        addr_low_reg <= reg_wdata;
      end
      if (reg_addr == `PFSWC_OFS_ADDR_HIGH) begin
        addr_high_reg <= reg_wdata[4:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_low_reg <= '0;
      data_high_reg <= '0;
    end else if (state_reg == pfswc_pkg::PFSWC_READ) begin
      data_low_reg <= flash_rdata[7:0];
      data_high_reg <= flash_rdata[DATA_W-1:8];
    end else if (reg_wr && reg_addr == `PFSWC_OFS_DATA_LOW) begin
      data_low_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == `PFSWC_OFS_DATA_HIGH) begin
      data_high_reg <= reg_wdata[5:0];
    end
  end

  // register read mux
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `PFSWC_OFS_DATA_LOW: reg_rdata = data_low_reg;
        `PFSWC_OFS_DATA_HIGH: reg_rdata = {2'b00, data_high_reg};
        `PFSWC_OFS_ADDR_LOW: reg_rdata = addr_low_reg;
        `PFSWC_OFS_ADDR_HIGH: reg_rdata = {3'b000, addr_high_reg};
        `PFSWC_OFS_CONTROL: begin
          reg_rdata = {1'b0, calib_space_select_reg, 3'b000, prog_write_enable_reg,
                       wr_bit_reg, rd_bit_reg};
        end
        `PFSWC_OFS_UNLOCK: reg_rdata = 8'h00;
        default: reg_rdata = 8'h00;
      endcase
    end
  end

  assign flash_addr = full_addr;
  assign flash_calib_sel = calib_space_select_reg;
  assign flash_read = (state_reg == pfswc_pkg::PFSWC_READ);
  assign fetch_steal = (state_reg == pfswc_pkg::PFSWC_READ);
  // erase only for the nibble-0011 word, the first block after a row edge
  assign flash_erase_row = (state_reg == pfswc_pkg::PFSWC_SETUP) &&
                           cnt_reg == '0 && last_word &&
                           addr_low_reg[3:0] == 4'h3;
  assign flash_prog_block = (state_reg == pfswc_pkg::PFSWC_PROG);
  assign cpu_halt = (state_reg == pfswc_pkg::PFSWC_SETUP) ||
                    (state_reg == pfswc_pkg::PFSWC_ERASE) ||
                    (state_reg == pfswc_pkg::PFSWC_PROG);
  assign test_access_en = rd_sync_reg[1] && !cp_sync_reg[2];
endmodule : pfswc_ctrl

//--- tb/pfswc_flash_model.sv
// behavioural flash array with a calibration area
`timescale 1ns/100ps
module pfswc_flash_model (
  input wire logic ref_clk,
  input wire logic [12:0] flash_addr,
  input wire logic flash_calib_sel,
  input wire logic flash_read,
  input wire logic flash_erase_row,
  input wire logic flash_prog_block,
  input wire logic [55:0] flash_prog_data,
  output logic [13:0] flash_rdata
);
  logic [13:0] mem [8192];
  logic [13:0] word;
  initial begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 14'(i * 7);
  end
  assign word = flash_calib_sel ? {1'b1, ~flash_addr} : mem[flash_addr];
  // array output is only valid while the read strobe is up
  assign flash_rdata = flash_read ? word : ~word;
  always @(posedge ref_clk) begin
    if (flash_erase_row)
      for (int j = 0; j < 16; j++)
        mem[{flash_addr[12:4], 4'h0} + j] = 14'h3FFF;
    if (flash_prog_block)
      for (int j = 0; j < 4; j++)
        mem[{flash_addr[12:2], 2'h0} + j] = flash_prog_data[14*j +: 14];
  end
endmodule : pfswc_flash_model

//--- tb/pfswc_ctrl_asserts.sv
// port assertions for the flash controller
`timescale 1ns/100ps
module pfswc_ctrl_asserts #(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 14
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_halt,
  input wire logic fetch_steal,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_calib_sel,
  input wire logic flash_read,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire logic flash_erase_row,
  input wire logic flash_prog_block
);
  logic [7:0] low_reg;
  logic held_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // remembers the low byte a read left until software overwrites it
  always_ff @(posedge ref_clk) begin
    if (srst || (reg_wr && reg_addr == 3'h0))
      held_reg <= 1'b0;
    else if (flash_read)
      held_reg <= 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (flash_read)
      low_reg <= flash_rdata[7:0];
  end
  property p_pad;
    reg_rd && reg_addr == 3'h4 |-> !reg_rdata[7] && reg_rdata[5:3] == 3'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("pad bits set");
  property p_nostore;
    reg_rd && reg_addr >= 3'h5 |-> reg_rdata == 8'h00;
  endproperty
  a_nostore: assert property (p_nostore) else $error("nonzero");
  property p_rdpulse;
    flash_read |-> fetch_steal ##1 !flash_read;
  endproperty
  a_rdpulse: assert property (p_rdpulse) else $error("read");
  property p_rdhold;
    held_reg && reg_rd && reg_addr == 3'h0 |-> reg_rdata == low_reg;
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("data lost");
  property p_nib;
    flash_erase_row |-> flash_addr[3:0] == 4'h3 && cpu_halt;
  endproperty
  a_nib: assert property (p_nib) else $error("bad erase");
  // eight erase cycles: the bench runs the design with ERASE_CYCLES 8
  property p_erase;
    flash_erase_row |=> cpu_halt [*8] ##[1:2] flash_prog_block;
  endproperty
  a_erase: assert property (p_erase) else $error("erase");
  property p_calib;
    flash_prog_block |-> !flash_calib_sel && cpu_halt;
  endproperty
  a_calib: assert property (p_calib) else $error("calib prog");
  property p_setup;
    $rose(cpu_halt) && flash_addr[1:0] != 2'h3 |-> cpu_halt [*2] ##1 !cpu_halt;
  endproperty
  a_setup: assert property (p_setup) else $error("setup");
endmodule : pfswc_ctrl_asserts
bind pfswc_ctrl pfswc_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_pfswc_ctrl_asserts (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .cpu_halt(cpu_halt), .fetch_steal(fetch_steal), .flash_addr(flash_addr),
  .flash_calib_sel(flash_calib_sel), .flash_read(flash_read),
  .flash_rdata(flash_rdata), .flash_erase_row(flash_erase_row),
  .flash_prog_block(flash_prog_block));

//--- tb/tb_program_flash_self_write_controller.sv
// self-checking bench for the flash self-write controller
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_program_flash_self_write_controller;
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
  logic [1:0] wp = 2'h0;
  logic cp = 1'b0, tar = 1'b0, tae, halt, steal, cal, frd, er, pg;
  logic [12:0] fa;
  logic [13:0] frdata;
  logic [55:0] pdata;
  logic [13:0] wbuf [4];
  int num_errors = 0, compares = 0, halts = 0, base, ta;
  int exp_mem [int];
  pfswc_ctrl #(.ERASE_CYCLES(8), .PWRUP_CYCLES(16)) u_pfswc_ctrl (
    .ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .write_protect_bits(wp), .code_protect_bit(cp),
    .serial_programming_mode(1'b0), .test_access_req(tar),
    .test_access_en(tae), .cpu_halt(halt), .fetch_steal(steal),
    .flash_addr(fa), .flash_calib_sel(cal), .flash_read(frd),
    .flash_rdata(frdata), .flash_erase_row(er), .flash_prog_block(pg),
    .flash_prog_data(pdata));
  pfswc_flash_model u_pfswc_flash_model (.ref_clk(ref_clk),
    .flash_addr(fa), .flash_calib_sel(cal), .flash_read(frd),
    .flash_erase_row(er), .flash_prog_block(pg),
    .flash_prog_data(pdata), .flash_rdata(frdata));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (halt === 1'b1)
      halts++;
  end
  function automatic int emem(input int a);
    return exp_mem.exists(a) ? exp_mem[a] : (a * 7) & 32'h3FFF;
  endfunction : emem
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic rdw(input int a, input logic c);
    logic [13:0] w;
    w = c ? 14'(32'h2000 | (~a & 32'h1FFF)) : 14'(emem(a));
    wr(3'h2, 8'(a));
    wr(3'h3, 8'(a >> 8));
    wr(3'h4, {1'b0, c, 6'h05});
    rd(3'h0);
    `CHK(v, w[7:0])
    rd(3'h1);
    `CHK(v, {2'h0, w[13:8]})
    rd(3'h4);
    `CHK(v, {1'b0, c, 6'h04})
  endtask : rdw
  task automatic go(input logic [7:0] u1);
    wr(3'h5, u1);
    wr(3'h5, 8'hAA);
    wr(3'h4, 8'h06);
    @(negedge ref_clk);
    for (int n = 0; n < 40 && halt === 1'b1; n++)
      @(negedge ref_clk);
  endtask : go
  task automatic wrw(input int a, input logic [13:0] d, input logic [7:0] u1,
                     input logic ok);
    int h;
    h = halts;
    wr(3'h2, 8'(a));
    wr(3'h3, 8'(a >> 8));
    wr(3'h0, d[7:0]);
    wr(3'h1, {2'h0, d[13:8]});
    go(u1);
    `CHK(halts > h, ok)
    rd(3'h4);
    `CHK(v[1], 1'b0)
    if (ok) begin
      wbuf[a % 4] = d;
      if (a % 16 == 3)
        for (int j = 0; j < 16; j++) exp_mem[a - 3 + j] = 32'h3FFF;
      if (a % 4 == 3)
        for (int j = 0; j < 4; j++) exp_mem[a - 3 + j] = wbuf[j];
    end
  endtask : wrw
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(63830));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(3'h4);
    `CHK(v, 8'h00)
    wr(3'h4, 8'h04);
    go(8'h55);
    `CHK(halts, 0)
    repeat (20) @(posedge ref_clk);
    wr(3'h4, 8'hFC);
    rd(3'h4);
    `CHK(v, 8'h44)
    for (int i = 5; i < 8; i++) begin
      wr(3'(i), 8'($urandom));
      rd(3'(i));
      `CHK(v, 8'h00)
    end
    for (int i = 0; i < 6; i++)
      rdw($urandom_range(8191, 0), i[0]);
    base = 16 * $urandom_range(511, 0);
    wr(3'h4, 8'h04);
    for (int j = 0; j < 8; j++)
      wrw(base + j, 14'($urandom), 8'h55, 1'b1);
    // change one word only: the others are read back and rewritten
    for (int j = 8; j < 12; j++) begin
      if (j != 9)
        rdw(base + j, 1'b0);
      wrw(base + j, j == 9 ? 14'h2AAA : 14'(emem(base + j)), 8'h55,
          1'b1);
    end
    for (int j = 0; j < 16; j++)
      rdw(base + j, 1'b0);
    // wrong unlock, enable clear, protected quarter, calibration space
    for (int k = 0; k < 4; k++) begin
      ta = (k == 2) ? 3 : base + 3;
      wp <= (k == 2) ? 2'h2 : 2'h0;
      wr(3'h4, k == 1 ? 8'h00 : (k == 3 ? 8'h44 : 8'h04));
      wrw(ta, 14'h1234, k == 0 ? 8'h54 : 8'h55, 1'b0);
      wr(3'h4, 8'h04);
      rdw(ta, 1'b0);
    end
    tar <= 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK(tae, 1'b1)
    @(posedge ref_clk);
    cp <= 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK(tae, 1'b0)
    rdw(base + 5, 1'b0);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(3'h4);
    `CHK(v, 8'h00)
    finish_test();
  end
endmodule : tb_program_flash_self_write_controller
